// File: verilog/fscd_defs.vh
// Purpose: constants for the flash setting command decoder
// Assumes: opcodes are 8 bits, shifted msb first
// Notes: definitions only
`ifndef FSCD_DEFS_VH
`define FSCD_DEFS_VH
`define FSCD_OP_SET_LATCH 8'h06
`define FSCD_OP_CLR_LATCH 8'h04
`define FSCD_OP_RD_STAT 8'h05
`define FSCD_OP_RD_CONF 8'h15
`define FSCD_OP_WR_STCF 8'h01
`define FSCD_OP_RD_EXT 8'hC8
`define FSCD_OP_WR_EXT 8'hC5
`define FSCD_OP_PROT_SEL 8'h68
`define FSCD_OP_ENT_QUAD 8'h35
`define FSCD_OP_LV_QUAD 8'hF5
`define FSCD_OP_ENT_WIDE 8'hB7
`define FSCD_OP_LV_WIDE 8'hE9
`define FSCD_OP_SUSP_A 8'hB0
`define FSCD_OP_SUSP_B 8'h75
`define FSCD_OP_RESM_A 8'h30
`define FSCD_OP_RESM_B 8'h7A
`define FSCD_OP_PWR_DN 8'hB9
`define FSCD_OP_WAKE 8'hAB
`define FSCD_OP_BURST 8'hC0
`define FSCD_OP_RD_BOOT 8'h16
`define FSCD_OP_WR_BOOT 8'h17
`define FSCD_OP_ER_BOOT 8'h18
`define FSCD_RST_STAT 8'h00
`define FSCD_RST_CONF 8'h00
`define FSCD_RST_EXT 8'h00
`define FSCD_RST_BURST 8'h00
`define FSCD_RST_BOOT 32'hFFFFFFFF
`define FSCD_DUMMY_LO_BIT 6
`define FSCD_DUMMY_HI_BIT 7
`endif

// File: verilog/fscd_decoder.v
// Purpose: register and setting command decoder of a serial flash
// Assumes: serial clock much slower than core_clk; data is sampled on sclk rise
// Notes: array commands are outside; dummy select and wide flag are exported for them
`timescale 1ns/1ps
`include "fscd_defs.vh"
module fscd_decoder (
	// clock and reset
	input wire core_clk,
	input wire rstn,
	// serial link pins
	input wire csN,
	input wire sclk,
	input wire [3:0] dataIn,
	output reg [3:0] dataOut,
	output reg [3:0] dataOeN,
	// state exported to the rest of the device
	output reg writeEnableLatch,
	output reg fourLineMode,
	output reg wideAddrFlag,
	output reg blockProtectMode,
	output reg powerDown,
	output reg suspended,
	output reg [1:0] dummySel,
	output reg [7:0] burstLength,
	output reg [7:0] statusReg,
	output reg [7:0] configReg,
	output reg [7:0] extAddrReg,
	output reg [31:0] bootReg
);
	localparam ST_IDLE = 3'h0;
	localparam ST_OPC = 3'h1;
	localparam ST_WDATA = 3'h2;
	localparam ST_RDATA = 3'h3;
	localparam ST_SKIP = 3'h4;

	// which register a read command returns
	function [31:0] readSource;
		input [7:0] op;
		input [7:0] st;
		input [7:0] cf;
		input [7:0] ea;
		input [31:0] br;
		begin
			case (op)
				`FSCD_OP_RD_STAT: readSource = {st, st, st, st};
				`FSCD_OP_RD_CONF: readSource = {cf, cf, cf, cf};
				`FSCD_OP_RD_EXT: readSource = {ea, ea, ea, ea};
				`FSCD_OP_RD_BOOT: readSource = br;
				default: readSource = 32'h00000000;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// two-stage synchronisers for all link inputs
	reg [5:0] syncA_ff;
	reg [5:0] syncB_ff;
	reg sclkPrev_ff;
	always @(posedge core_clk) begin
		syncA_ff <= {csN, sclk, dataIn};
		syncB_ff <= syncA_ff;
		sclkPrev_ff <= syncB_ff[4];
	end
	wire csSyncN = syncB_ff[5];
	wire sclkSync = syncB_ff[4];
	wire [3:0] dinSync = syncB_ff[3:0];
	wire sclkRise = sclkSync & ~sclkPrev_ff;
	wire sclkFall = ~sclkSync & sclkPrev_ff;

	////////////////////////////////////////////////////////////////////////////
	// shift state
	reg [2:0] state_ff;
	reg [7:0] shift_ff;
	reg [3:0] bitCnt_ff;
	reg [7:0] opcode_ff;
	reg [2:0] byteCnt_ff;
	reg [31:0] rdShift_ff;
	reg [31:0] wrAcc_ff;

	// a byte completes after 8 single-line or 2 four-line clocks
	wire [3:0] bitsPerByte = fourLineMode ? 4'h2 : 4'h8;
	wire [7:0] shiftNext = fourLineMode ? {shift_ff[3:0], dinSync} : {shift_ff[6:0], dinSync[0]};
	wire byteDone = sclkRise && (bitCnt_ff + 4'h1 == bitsPerByte);

	// mode checks: single-only and four-only opcodes
	function opOk;
		input [7:0] op;
		input quad;
		begin
			case (op)
				`FSCD_OP_PROT_SEL, `FSCD_OP_ENT_QUAD, `FSCD_OP_RD_BOOT,
				`FSCD_OP_WR_BOOT, `FSCD_OP_ER_BOOT: opOk = ~quad;
				`FSCD_OP_LV_QUAD: opOk = quad;
				default: opOk = 1'b1;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// command engine; select rise always ends a frame
	always @(posedge core_clk) begin
		if (!rstn) begin
			state_ff <= ST_IDLE;
			shift_ff <= 8'h00;
			bitCnt_ff <= 4'h0;
			opcode_ff <= 8'h00;
			byteCnt_ff <= 3'h0;
			rdShift_ff <= 32'h00000000;
			wrAcc_ff <= 32'h00000000;
			dataOut <= 4'h0;
			dataOeN <= 4'hF;
			writeEnableLatch <= 1'b0;
			fourLineMode <= 1'b0;
			wideAddrFlag <= 1'b0;
			blockProtectMode <= 1'b0;
			powerDown <= 1'b0;
			suspended <= 1'b0;
			dummySel <= 2'h0;
			burstLength <= `FSCD_RST_BURST;
			statusReg <= `FSCD_RST_STAT;
			configReg <= `FSCD_RST_CONF;
			extAddrReg <= `FSCD_RST_EXT;
			bootReg <= `FSCD_RST_BOOT;
		end else begin
			// dummy cycle select tracks config bits 7:6
			dummySel <= {configReg[`FSCD_DUMMY_HI_BIT], configReg[`FSCD_DUMMY_LO_BIT]};
			if (csSyncN) begin
				// frame end commits writes of data bytes received
				if (state_ff == ST_WDATA) begin
					if (opcode_ff == `FSCD_OP_WR_STCF && byteCnt_ff == 3'h1) begin
						statusReg <= wrAcc_ff[7:0];
					end
					if (opcode_ff == `FSCD_OP_WR_STCF && byteCnt_ff == 3'h2) begin
						statusReg <= wrAcc_ff[15:8];
						configReg <= wrAcc_ff[7:0];
					end
					if (opcode_ff == `FSCD_OP_WR_EXT && byteCnt_ff == 3'h1) begin
						extAddrReg <= wrAcc_ff[7:0];
					end
					if (opcode_ff == `FSCD_OP_BURST && byteCnt_ff == 3'h1) begin
						burstLength <= wrAcc_ff[7:0];
					end
					if (opcode_ff == `FSCD_OP_WR_BOOT && byteCnt_ff == 3'h4) begin
						bootReg <= wrAcc_ff; // four or more bytes; the first four are kept
					end
				end
				state_ff <= ST_IDLE;
				bitCnt_ff <= 4'h0;
				byteCnt_ff <= 3'h0;
				dataOeN <= 4'hF;
			end else begin
				case (state_ff)
					ST_IDLE: begin
						state_ff <= ST_OPC;
						bitCnt_ff <= 4'h0;
					end
					ST_OPC: begin
						if (sclkRise) begin
							shift_ff <= shiftNext;
							bitCnt_ff <= bitCnt_ff + 4'h1;
						end
						if (byteDone) begin
							opcode_ff <= shiftNext;
							bitCnt_ff <= 4'h0;
							wrAcc_ff <= 32'h00000000;
							rdShift_ff <= readSource(shiftNext, statusReg, configReg,
								extAddrReg, bootReg);
							state_ff <= ST_SKIP;
							// only wake is heard during deep power-down
							if (opOk(shiftNext, fourLineMode) &&
								(!powerDown || shiftNext == `FSCD_OP_WAKE)) begin
								case (shiftNext)
									`FSCD_OP_SET_LATCH: writeEnableLatch <= 1'b1;
									`FSCD_OP_CLR_LATCH: writeEnableLatch <= 1'b0;
									`FSCD_OP_RD_STAT, `FSCD_OP_RD_CONF, `FSCD_OP_RD_EXT,
									`FSCD_OP_RD_BOOT: state_ff <= ST_RDATA;
									`FSCD_OP_WR_STCF, `FSCD_OP_WR_EXT, `FSCD_OP_BURST,
									`FSCD_OP_WR_BOOT: state_ff <= ST_WDATA;
									`FSCD_OP_PROT_SEL: blockProtectMode <= 1'b1;
									`FSCD_OP_ENT_QUAD: fourLineMode <= 1'b1;
									`FSCD_OP_LV_QUAD: fourLineMode <= 1'b0;
									`FSCD_OP_ENT_WIDE: wideAddrFlag <= 1'b1;
									`FSCD_OP_LV_WIDE: wideAddrFlag <= 1'b0;
									`FSCD_OP_SUSP_A, `FSCD_OP_SUSP_B: suspended <= 1'b1;
									`FSCD_OP_RESM_A, `FSCD_OP_RESM_B: suspended <= 1'b0;
									`FSCD_OP_PWR_DN: powerDown <= 1'b1;
									`FSCD_OP_WAKE: powerDown <= 1'b0;
									`FSCD_OP_ER_BOOT: bootReg <= `FSCD_RST_BOOT;
									default: state_ff <= ST_SKIP;
								endcase
							end
						end
					end
					ST_WDATA: begin
						if (sclkRise) begin
							shift_ff <= shiftNext;
							bitCnt_ff <= bitCnt_ff + 4'h1;
						end
						// extra bytes beyond the limit are dropped
						if (byteDone) begin
							bitCnt_ff <= 4'h0;
							if (byteCnt_ff != 3'h4) begin
								wrAcc_ff <= {wrAcc_ff[23:0], shiftNext};
								byteCnt_ff <= byteCnt_ff + 3'h1;
							end
						end
					end
					ST_RDATA: begin
						// drive on falling edge so host samples stable data on rise
						if (sclkFall) begin
							if (fourLineMode) begin
								dataOut <= rdShift_ff[31:28];
								dataOeN <= 4'h0;
								rdShift_ff <= {rdShift_ff[27:0], rdShift_ff[31:28]};
							end else begin
								dataOut <= {2'h0, rdShift_ff[31], 1'b0};
								dataOeN <= 4'hD; // single-line output on line 1
								rdShift_ff <= {rdShift_ff[30:0], rdShift_ff[31]};
							end
						end
					end
					ST_SKIP: begin
						bitCnt_ff <= 4'h0;
					end
					default: state_ff <= ST_IDLE;
				endcase
			end
		end
	end
endmodule

// File: tb/fscd_assertions.sv
// Purpose: port checks on the setting command decoder
// Assumes: single core clock domain, rstn synchronous active low
// Notes: hiCnt_ff counts core cycles since csN was last seen low
`timescale 1ns/1ps
module fscd_assertions (
	// clock and reset
	input logic core_clk,
	input logic rstn,
	// link
	input logic csN,
	input logic [3:0] dataOeN,
	// state
	input logic writeEnableLatch,
	input logic fourLineMode,
	input logic blockProtectMode,
	input logic powerDown,
	input logic [7:0] configReg,
	input logic [1:0] dummySel,
	input logic [31:0] bootReg
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	logic [3:0] hiCnt_ff;
	logic [3:0] nxt_hiCnt;
	logic [3:0] flags;
	////////////////////////////////////////////////////////////////////////
	// saturating count, so a long idle gap never wraps back into a frame
	assign nxt_hiCnt = (!rstn || !csN) ? 4'h0 : hiCnt_ff + {3'h0, hiCnt_ff != 4'hF};
	assign flags = {writeEnableLatch, fourLineMode, blockProtectMode, powerDown};
	always @(posedge core_clk) hiCnt_ff <= nxt_hiCnt;
	a_flags_framed: assert property ($changed(flags) |-> hiCnt_ff < 4'h6)
		else $error("flag moved outside a frame");
	a_oe_idle: assert property (hiCnt_ff >= 4'h6 |-> dataOeN == 4'hF)
		else $error("link driven while deselected");
	a_single_read_oe: assert property (!fourLineMode && dataOeN != 4'hF |-> dataOeN == 4'hD)
		else $error("single-line read enables wrong lines");
	a_dummy_follow: assert property ($stable(configReg) |=> dummySel == $past(configReg[7:6]))
		else $error("dummy select not from config bits");
	a_protect_single: assert property ($rose(blockProtectMode) |-> !fourLineMode)
		else $error("protect mode set in four-line mode");
	a_quad_from_single: assert property ($rose(fourLineMode) |-> !$past(powerDown))
		else $error("four-line entered while powered down");
	a_boot_single: assert property ($changed(bootReg) |-> !fourLineMode)
		else $error("boot register moved in four-line mode");
	a_pdn_hold_wel: assert property (powerDown [*2] |-> $stable(writeEnableLatch))
		else $error("latch moved in power-down");
	c_quad: cover property ($rose(fourLineMode));
	c_pdn: cover property ($rose(powerDown));
	c_read: cover property (dataOeN == 4'hD);
	c_quad_read: cover property (dataOeN == 4'h0);
endmodule

// File: tb/fscd_host.sv
// Purpose: host controller model framing commands on the serial link
// Assumes: sclk period 8 core cycles, idle low between frames
// Notes: rd collects line 1 (single) or all lines (four-line) just before each sclk rise
`timescale 1ns/1ps
module fscd_host (
	// clock
	input logic core_clk,
	// link
	input logic [3:0] dataOut,
	input logic [3:0] dataOeN,
	output logic csN,
	output logic sclk,
	output logic [3:0] dataIn
);
	logic [31:0] rd;
	logic [3:0] seen;
	initial begin
		csN = 1'b1;
		sclk = 1'b0;
		dataIn = 4'h0;
	end
	////////////////////////////////////////////////////////////////////////
	// moves always land just after a core edge
	task automatic waitc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// nb bytes of b, msb first; released lines flip so stale data never passes
	task automatic frame(input bit q, input int nb, input logic [39:0] b);
		int i;
		csN = 1'b0;
		for (i = 0; i < nb * 8 / (q ? 4 : 1); i++) begin
			dataIn = q ? b[39-4*i -: 4] : {~dataIn[3:1], b[39-i]};
			waitc(4);
			// a released line reads as the inverse of its last value, so no stale match
			seen = dataOut ^ dataOeN;
			rd = q ? {rd[27:0], seen} : {rd[30:0], seen[1]};
			sclk = 1'b1;
			waitc(4);
			sclk = 1'b0;
		end
		waitc(8);
		csN = 1'b1;
		dataIn = ~dataIn;
		waitc(8);
	endtask
endmodule

// File: tb/test_fscd_decoder.sv
// Purpose: self-checking bench for the setting command decoder
// Assumes: host model frames every command
// Notes: expected values are the written bytes and opcode effects
`timescale 1ns/1ps
module test_fscd_decoder;
	logic core_clk, rstn, csN, sclk, wrLatch, quad, wide, prot, pdn, susp;
	logic [3:0] dataIn, dataOut, dataOeN;
	logic [1:0] dSel;
	logic [7:0] burst, stat, conf, ext;
	logic [31:0] boot;
	int fail_count, n_checks, i;
	fscd_host u_host (.core_clk(core_clk), .dataOut(dataOut), .dataOeN(dataOeN), .csN(csN),
		.sclk(sclk), .dataIn(dataIn));
	fscd_decoder u_dut (.core_clk(core_clk), .rstn(rstn), .csN(csN), .sclk(sclk),
		.dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN), .writeEnableLatch(wrLatch),
		.fourLineMode(quad), .wideAddrFlag(wide), .blockProtectMode(prot), .powerDown(pdn),
		.suspended(susp), .dummySel(dSel), .burstLength(burst), .statusReg(stat),
		.configReg(conf), .extAddrReg(ext), .bootReg(boot));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done;
		if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic f(input bit q, input int nb, input logic [39:0] b);
		u_host.frame(q, nb, b);
	endtask
	task automatic s_regs;
		f(0, 1, 40'h0600000000);
		chk("latch", wrLatch, 1);
		f(0, 1, 40'h0400000000);
		chk("latch", wrLatch, 0);
		f(0, 3, 40'h01A5C30000);
		chk("stat", stat, 8'hA5);
		chk("conf", conf, 8'hC3);
		chk("dsel", dSel, 2'h3);
		f(0, 2, 40'h0500000000);
		chk("rdstat", u_host.rd[7:0], 8'hA5);
		f(0, 2, 40'h1500000000);
		chk("rdconf", u_host.rd[7:0], 8'hC3);
		f(0, 2, 40'h013C000000);
		chk("stat1", {stat, conf}, 16'h3CC3);
		f(0, 2, 40'hC55A000000);
		chk("ext", ext, 8'h5A);
		f(0, 2, 40'hC800000000);
		chk("rdext", u_host.rd[7:0], 8'h5A);
		f(0, 2, 40'hC020000000);
		chk("burst", burst, 8'h20);
	endtask
	task automatic s_modes;
		logic [7:0] ops [6] = '{8'hB7, 8'hB0, 8'h30, 8'h75, 8'h7A, 8'hE9};
		for (i = 0; i < 6; i++) begin
			f(0, 1, {ops[i], 32'h0});
			chk("wide", wide, 6'b111110 >> (5 - i) & 1);
			chk("susp", susp, 6'b010100 >> (5 - i) & 1);
		end
	endtask
	task automatic s_boot;
		f(0, 5, 40'h1712345678);
		chk("boot", boot, 32'h12345678);
		f(0, 5, 40'h1600000000);
		chk("rdboot", u_host.rd, 32'h12345678);
		f(0, 1, 40'h1800000000);
		f(0, 4, 40'h17ABCDEF00);
		chk("boot3", boot, 32'hFFFFFFFF);
	endtask
	task automatic s_quad;
		f(0, 1, 40'h3500000000);
		chk("quad", quad, 1);
		f(1, 1, 40'h6800000000);
		chk("prot", prot, 0);
		f(1, 1, 40'h0600000000);
		chk("latch", wrLatch, 1);
		// four-line status read: status still holds the last byte written by s_regs
		f(1, 2, 40'h0500000000);
		chk("qrdstat", u_host.rd[7:0], 8'h3C);
		f(1, 1, 40'hF500000000);
		f(0, 1, 40'hF500000000);
		chk("quad", quad, 0);
		f(0, 1, 40'h6800000000);
		chk("prot", prot, 1);
		f(0, 1, 40'hB900000000);
		f(0, 1, 40'h0400000000);
		chk("pdn", {pdn, wrLatch}, 2'h3);
		f(0, 1, 40'hAB00000000);
		chk("pdn", pdn, 0);
	endtask
	// stimulus moves 1 ns after each rising edge
	initial begin
		core_clk = 0;
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		#2000000;
		fail_count++;
		test_done;
	end
	initial begin
		rstn = 0;
		repeat (12) @(posedge core_clk);
		#1;
		rstn = 1;
		u_host.waitc(4);
		chk("boot", boot, 32'hFFFFFFFF);
		s_regs;
		s_modes;
		s_boot;
		s_quad;
		test_done;
	end
endmodule
bind fscd_decoder fscd_assertions u_chk (.core_clk(core_clk), .rstn(rstn), .csN(csN),
	.dataOeN(dataOeN), .writeEnableLatch(writeEnableLatch), .fourLineMode(fourLineMode),
	.blockProtectMode(blockProtectMode), .powerDown(powerDown), .configReg(configReg),
	.dummySel(dummySel), .bootReg(bootReg));
